// ### rtl/lcd_port_dev.sv
// Summary of operation
// - Shift only while chip select low.
// - One 16-bit word per select period.
// - Sample data on shift clock rise.
// - Chip select rise delivers the word.
// - Bits beyond sixteen are dropped.
// - Short words are discarded entirely.
// - Host sends exactly sixteen clocks.
// - Most significant bit comes first.
// - RAM write steps the address counter.
// - Key read turns pin at eighth fall.
// - Long reset pin low resets all but buffer and timing.
// - Timing base from 145 kHz tick.
// - Host may initialize by instructions.
// - Key read returns line and column bits.
// - Entry bit one increments, zero decrements.
module lcd_port_dev
(
	input wire logic clk, // System clock, 20 MHz.
	input wire logic arst_n, // Asynchronous reset, active low.
	lcd_serial_if.dev link, // Serial pins.
	input wire logic [3:0] key_line_bits, // Key line inputs from the scanner.
	input wire logic [2:0] key_column_bits, // Key column code from the scanner.
	output logic word_valid, // Received word available.
	input wire logic word_ready, // Decoder takes the word.
	output logic [15:0] word_data, // Received word.
	output logic word_overrun, // Pulse: a word lost to a full buffer.
	output logic [lcd_port_pkg::ADDR_W-1:0] address_counter, // RAM address counter.
	output logic entry_increment, // Current entry direction.
	output logic sys_reset, // System reset in progress; word buffer and timing base keep running.
	output logic timing_tick // Display timing base pulse.
);
	import lcd_port_pkg::*;

	logic cs_q;
	logic sck_q;
	logic [15:0] shifter;
	logic [CNT_W-1:0] bit_cnt;
	logic driving;
	logic [7:0] out_byte;
	logic dout;
	logic [RST_CNT_W-1:0] rst_cnt;
	logic [7:0] osc_cnt;
	logic [15:0] cap_word;
	logic cap_valid;

	// Edge detection on the synchronous pins.
	wire selected = !link.cs_n;
	wire cs_fall = cs_q && !link.cs_n;
	wire cs_rise = !cs_q && link.cs_n;
	wire sck_rise = selected && !sck_q && link.sck;
	wire sck_fall = selected && sck_q && !link.sck;
	wire full = bit_cnt >= CNT_FULL;
	wire take_bit = sck_rise && !full && !driving;
	wire word_ok = cs_rise && full;
	wire is_keyread = shifter[7:0] == OP_KEYREAD;
	wire turn = sck_fall && bit_cnt == CNT_TURN && is_keyread;
	wire fifo_in_ready;

	// Pin edges and the bit counter; select fall starts from zero.
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cs_q <= 1'b1;
			sck_q <= 1'b0;
			bit_cnt <= '0;
			shifter <= '0;
		end
		else
		begin
			cs_q <= link.cs_n;
			sck_q <= link.sck;
			if (cs_fall || sys_reset)
			begin
				bit_cnt <= '0;
				shifter <= '0;
			end
			else if (take_bit)
			begin
				bit_cnt <= bit_cnt + 1'b1;
				shifter <= {shifter[14:0], link.data_line};
			end
			else if (driving && sck_rise && !full)
				bit_cnt <= bit_cnt + 1'b1;
		end
	end

	// Key read output: the pin turns at the eighth fall, releases at select rise.
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			driving <= 1'b0;
			out_byte <= '0;
			dout <= 1'b1;
		end
		else if (cs_rise || sys_reset)
		begin
			driving <= 1'b0;
			dout <= 1'b1;
		end
		else if (turn)
		begin
			driving <= 1'b1;
			dout <= key_line_bits[3];
			out_byte <= {key_line_bits[2:0], 1'b0, key_column_bits, 1'b0};
		end
		else if (driving && sck_fall)
		begin
			dout <= out_byte[7];
			out_byte <= {out_byte[6:0], 1'b0};
		end
	end
	assign link.data_dev_o = dout;
	assign link.data_dev_oe_n = !driving;

	// Word capture at select rise; the key read word is not queued.
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cap_word <= '0;
			cap_valid <= 1'b0;
			word_overrun <= 1'b0;
		end
		else
		begin
			cap_valid <= word_ok && !driving && !sys_reset;
			word_overrun <= cap_valid && !fifo_in_ready;
			if (word_ok)
				cap_word <= shifter;
		end
	end

	word_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_D), .AW(FIFO_AW)) u_fifo (
		.clk(clk),
		.arst_n(arst_n),
		.in_valid(cap_valid),
		.in_ready(fifo_in_ready),
		.in_data(cap_word),
		.out_valid(word_valid),
		.out_ready(word_ready),
		.out_data(word_data)
	);

	// Decoder-side effects of words leaving the buffer.
	wire taken = word_valid && word_ready;
	wire is_write = (word_data[15:8] & OP_WRITE_MASK) == OP_WRITE;
	wire is_entry = (word_data[15:8] & OP_ENTRY_MASK) == OP_ENTRY;
	wire is_setaddr = word_data[15:8] == OP_SETADDR_DD;
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			address_counter <= ADDR_RESET;
			entry_increment <= 1'b1;
		end
		else if (sys_reset)
		begin
			address_counter <= ADDR_RESET;
			entry_increment <= 1'b1;
		end
		else if (taken)
		begin
			if (is_entry)
				entry_increment <= word_data[ENTRY_ID_BIT];
			else if (is_setaddr)
				address_counter <= word_data[7:0];
			else if (is_write && entry_increment)
				address_counter <= address_counter + 1'b1;
			else if (is_write)
				address_counter <= address_counter - 1'b1;
		end
	end

	// Reset pin filter: low held long enough gives a system reset (word buffer and timing base excepted).
	// Any high sample restarts the count, so short glitches never add up to a reset.
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rst_cnt <= '0;
			sys_reset <= 1'b0;
		end
		else if (link.reset_pin_n)
		begin
			rst_cnt <= '0;
			sys_reset <= 1'b0;
		end
		else if (rst_cnt >= RST_CNT_W'(RESET_CYC - 1))
			sys_reset <= 1'b1;
		else
			rst_cnt <= rst_cnt + 1'b1;
	end

	// Oscillator period tick for display timing.
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			osc_cnt <= '0;
			timing_tick <= 1'b0;
		end
		else
		begin
			timing_tick <= osc_cnt == 8'(OSC_DIV - 1);
			osc_cnt <= (osc_cnt == 8'(OSC_DIV - 1)) ? '0 : osc_cnt + 1'b1;
		end
	end
endmodule

// ### rtl/lcd_port_pkg.sv
package lcd_port_pkg;
	localparam int WORD_BITS = 16;
	localparam int CNT_W = 5;
	localparam logic [4:0] CNT_FULL = 5'h10;
	localparam logic [4:0] CNT_TURN = 5'h08;
	localparam int ADDR_W = 8;
	localparam int FIFO_W = 16;
	localparam int FIFO_D = 8;
	localparam int FIFO_AW = 3;
	// Opcode byte of the key-data read, carried in the upper byte.
	localparam logic [7:0] OP_KEYREAD = 8'hA7;
	// Upper byte pattern of a RAM data write (1001_x000).
	localparam logic [7:0] OP_WRITE_MASK = 8'hF7;
	localparam logic [7:0] OP_WRITE = 8'h90;
	// Entry mode opcode in the upper byte; word bit 1 selects increment.
	localparam logic [7:0] OP_ENTRY = 8'h84;
	localparam logic [7:0] OP_ENTRY_MASK = 8'hFC;
	localparam int ENTRY_ID_BIT = 1;
	localparam logic [7:0] OP_SETADDR_DD = 8'h93;
	localparam logic [7:0] ADDR_RESET = 8'h00;
	// Oscillator and reset timing.
	localparam real CLK_NS = 50.0;
	localparam real OSC_PERIOD_NS = 6900.0;
	localparam real RESET_MIN_NS = 1200000.0;
	localparam int OSC_DIV = int'(OSC_PERIOD_NS / CLK_NS) > 1 ? int'(OSC_PERIOD_NS / CLK_NS) : 1;
	localparam int RESET_CYC = 24000;
	localparam int RST_CNT_W = 16;
	// Host shift clock half period, giving 1 us per bit at 20 MHz.
	localparam int HALF_CYC = 10;
	localparam int HALF_W = 4;
endpackage

// ### rtl/lcd_serial_if.sv
interface lcd_serial_if;
	logic cs_n;
	logic sck;
	logic data_host_o;
	logic data_host_oe_n;
	logic data_dev_o;
	logic data_dev_oe_n;
	logic reset_pin_n;
	// Wire level: pulled high when nobody drives.
	wire data_line = !data_dev_oe_n ? data_dev_o : (!data_host_oe_n ? data_host_o : 1'b1);
	modport dev (input cs_n, input sck, input data_line, input reset_pin_n,
		output data_dev_o, output data_dev_oe_n);
	modport host (output cs_n, output sck, output data_host_o, output data_host_oe_n,
		output reset_pin_n, input data_line);
endinterface

// ### rtl/word_fifo.sv
module word_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8,
	parameter int AW = 3
) (
	input wire logic clk, // System clock.
	input wire logic arst_n, // Asynchronous reset, active low.
	input wire logic in_valid, // Word offered.
	output logic in_ready, // Room for a word.
	input wire logic [WIDTH-1:0] in_data, // Word written.
	output logic out_valid, // Word available.
	input wire logic out_ready, // Drain accepts.
	output logic [WIDTH-1:0] out_data // Oldest word.
);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_ptr;
	logic [AW:0] rd_ptr;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;
	// Extra pointer bit tells full from empty without a separate counter.
	assign in_ready = !((wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
	assign out_valid = wr_ptr != rd_ptr;
	assign out_data = mem[rd_ptr[AW-1:0]];
	// Pointer update.
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end
		else
		begin
			if (push)
				wr_ptr <= wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= rd_ptr + 1'b1;
		end
	end
	// Storage needs no reset; the pointers guard it.
	always_ff @(posedge clk)
	begin
		if (push)
			mem[wr_ptr[AW-1:0]] <= in_data;
	end
endmodule

// ### rtl/lcd_port_host.sv
module lcd_port_host
(
	input wire logic clk, // System clock.
	input wire logic arst_n, // Asynchronous reset, active low.
	lcd_serial_if.host link, // Serial pins.
	input wire logic cmd_valid, // Word to send.
	output logic cmd_ready, // Idle and ready.
	input wire logic [15:0] cmd_data, // Word sent MSB first.
	input wire logic reset_req, // Pulse: drive the reset pin low.
	output logic [7:0] key_data, // Byte returned by a key read.
	output logic key_valid // Pulse: key byte ready.
);
	import lcd_port_pkg::*;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_SHIFT = 2'b01,
		ST_END = 2'b10,
		ST_RESET = 2'b11
	} state_t;

	state_t state;
	logic [15:0] sh;
	logic [CNT_W-1:0] cnt;
	logic [HALF_W-1:0] half;
	logic sck;
	logic keyread;
	logic [RST_CNT_W-1:0] rst_cnt;

	wire half_done = half == HALF_W'(HALF_CYC - 1);
	assign cmd_ready = state == ST_IDLE;
	assign link.cs_n = !(state == ST_SHIFT || (state == ST_END && !half_done));
	assign link.sck = sck;
	assign link.data_host_o = sh[15];
	// Release the line from the eighth fall of a key read onward.
	assign link.data_host_oe_n = !(state == ST_SHIFT && !(keyread && cnt >= CNT_TURN));
	assign link.reset_pin_n = state != ST_RESET;

	// Sixteen clocks per select period; reset pin held two cycles past the minimum.
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state <= ST_IDLE;
			sh <= '0;
			cnt <= '0;
			half <= '0;
			sck <= 1'b0;
			keyread <= 1'b0;
			key_data <= '0;
			key_valid <= 1'b0;
			rst_cnt <= '0;
		end
		else
		begin
			key_valid <= 1'b0;
			case (state)
				ST_IDLE:
				begin
					half <= '0;
					cnt <= '0;
					if (reset_req)
					begin
						state <= ST_RESET;
						rst_cnt <= '0;
					end
					else if (cmd_valid)
					begin
						state <= ST_SHIFT;
						sh <= cmd_data;
						keyread <= cmd_data[15:8] == OP_KEYREAD;
					end
				end
				ST_SHIFT:
				begin
					half <= half_done ? '0 : half + 1'b1;
					if (half_done && !sck)
						sck <= 1'b1;
					else if (half_done)
					begin
						sck <= 1'b0;
						cnt <= cnt + 1'b1;
						if (keyread && cnt >= CNT_TURN)
							key_data <= {key_data[6:0], link.data_line};
						else
							sh <= {sh[14:0], 1'b0};
						if (cnt == CNT_FULL - 1'b1)
							state <= ST_END;
					end
				end
				ST_END:
				begin
					half <= half_done ? '0 : half + 1'b1;
					if (half_done)
					begin
						state <= ST_IDLE;
						key_valid <= keyread;
					end
				end
				ST_RESET:
				begin
					rst_cnt <= rst_cnt + 1'b1;
					if (rst_cnt == RST_CNT_W'(RESET_CYC + 1))
						state <= ST_IDLE;
				end
				default:
					state <= ST_IDLE;
			endcase
		end
	end
endmodule

// ### tb/lcd_port_chk.sv
module lcd_port_chk (
	input wire logic clk, // System clock.
	input wire logic arst_n, // Reset, active low.
	input wire logic cs_n, // Chip select.
	input wire logic sck, // Shift clock.
	input wire logic data_host_o, // Host data.
	input wire logic data_host_oe_n, // Host drives when low.
	input wire logic data_dev_o, // Device data.
	input wire logic data_dev_oe_n // Device drives when low.
);
	timeunit 1ns;
	timeprecision 1ns;
	logic sck_q;
	logic [4:0] rises;
	logic [4:0] falls;
	// Edges are counted per select period, so one stray clock shows in the total.
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			sck_q <= 1'b0;
			rises <= 5'h00;
			falls <= 5'h00;
		end
		else
		begin
			sck_q <= sck;
			rises <= cs_n ? 5'h00 : rises + 5'((sck && !sck_q) ? 1 : 0);
			falls <= cs_n ? 5'h00 : falls + 5'((!sck && sck_q) ? 1 : 0);
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	sequence open_s;
		$fell(cs_n);
	endsequence
	sequence high_s;
		!cs_n && sck && $past(sck);
	endsequence
	word_len_a: assert property ($rose(cs_n) |-> rises == 5'h10)
		else $error("select period without sixteen clocks");
	no_extra_a: assert property (rises <= 5'h10)
		else $error("more than sixteen clocks");
	turn_eighth_a: assert property ($fell(data_dev_oe_n) |-> falls == 5'h08)
		else $error("data pin turned at the wrong fall");
	pin_release_a: assert property ($rose(cs_n) |-> ##[0:3] data_dev_oe_n)
		else $error("device still drives after select");
	no_fight_a: assert property (data_dev_oe_n || data_host_oe_n)
		else $error("both ends drive the data line");
	idle_clock_a: assert property (cs_n |-> !sck)
		else $error("shift clock moves while deselected");
	first_setup_a: assert property (open_s |-> !sck [*8])
		else $error("shift clock rose too soon after select");
	host_hold_a: assert property (high_s and !data_host_oe_n |-> $stable(data_host_o))
		else $error("host data moved while clock high");
	dev_hold_a: assert property (high_s and !data_dev_oe_n |-> $stable(data_dev_o))
		else $error("device data moved while clock high");
endmodule

// ### tb/testbench.sv
module testbench;
	import lcd_port_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, arst_n = 0, cmd_valid = 0, reset_req = 0, word_ready = 1;
	logic [15:0] cmd_data = 16'h0000, w;
	logic [3:0] key_line_bits = 4'h0;
	logic [2:0] key_column_bits = 3'h0;
	logic cmd_ready, key_valid, word_valid, word_overrun, entry_increment, sys_reset, timing_tick;
	logic [7:0] key_data;
	logic [15:0] word_data;
	logic [ADDR_W-1:0] address_counter;
	int num_errors = 0, checks = 0, seed = 32293, n, ticks, ovr = 0;
	logic [15:0] expq[$], keyq[$];
	always #25 clk = ~clk;
	lcd_serial_if lcd_serial_if_inst ();
	lcd_port_dev lcd_port_dev_inst (.clk, .arst_n, .link(lcd_serial_if_inst), .key_line_bits,
		.key_column_bits, .word_valid, .word_ready, .word_data, .word_overrun, .address_counter,
		.entry_increment, .sys_reset, .timing_tick);
	lcd_port_host lcd_port_host_inst (.clk, .arst_n, .link(lcd_serial_if_inst), .cmd_valid,
		.cmd_ready, .cmd_data, .reset_req, .key_data, .key_valid);
	lcd_port_chk lcd_port_chk_inst (.clk, .arst_n, .cs_n(lcd_serial_if_inst.cs_n),
		.sck(lcd_serial_if_inst.sck), .data_host_o(lcd_serial_if_inst.data_host_o),
		.data_host_oe_n(lcd_serial_if_inst.data_host_oe_n),
		.data_dev_o(lcd_serial_if_inst.data_dev_o),
		.data_dev_oe_n(lcd_serial_if_inst.data_dev_oe_n));
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// Every polling wait runs through here, so a hang ends as a counted failure.
	task automatic step();
		@(posedge clk);
		n++;
		if (n > 40000)
		begin
			num_errors++;
			finish_test();
		end
	endtask
	task automatic idle();
		n = 0;
		do step(); while (cmd_ready !== 1'b1);
		repeat (20) @(posedge clk);
	endtask
	// Waiting for an idle host keeps the select gap the host's own.
	task automatic send(input logic [15:0] v, input bit note);
		n = 0;
		do step(); while (cmd_ready !== 1'b1);
		cmd_valid <= 1'b1;
		cmd_data <= v;
		if (note)
			expq.push_back(v);
		@(posedge clk);
		cmd_valid <= 1'b0;
	endtask
	// The watcher pairs each delivered result with the oldest note.
	always @(posedge clk)
	begin
		if (word_valid === 1'b1 && word_ready === 1'b1)
			check("word_data", word_data, expq.size() ? expq.pop_front() : 16'hXXXX);
		if (key_valid === 1'b1)
			check("key_data", {8'h00, key_data}, keyq.size() ? keyq.pop_front() : 16'hXXXX);
		if (word_overrun === 1'b1)
			ovr++;
	end
	initial
	begin
		repeat (4) @(posedge clk);
		arst_n <= 1'b1;
		// Random words; a key read would not be queued, so that opcode is avoided.
		repeat (6)
		begin
			w = 16'($random(seed));
			if (w[15:8] == OP_KEYREAD)
				w[15] = 1'b0;
			send(w, 1);
		end
		// Both entry directions, each from a fresh start address.
		for (int d = 0; d < 2; d++)
		begin
			send({OP_ENTRY, 8'(d << ENTRY_ID_BIT)}, 1);
			send({OP_SETADDR_DD, 8'h10}, 1);
			repeat (3) send({OP_WRITE, 8'h41}, 1);
			idle();
			check("address_counter", 16'(address_counter), d ? 16'h0013 : 16'h000D);
			check("entry_increment", 16'(entry_increment), 16'(d));
		end
		// Key reads; the device answers in the second half of the word.
		repeat (2)
		begin
			key_line_bits <= 4'($random(seed));
			key_column_bits <= 3'($random(seed));
			@(posedge clk);
			keyq.push_back({8'h00, key_line_bits, 1'b0, key_column_bits});
			send({OP_KEYREAD, 8'h00}, 0);
			idle();
		end
		// A stalled reader fills the buffer and the ninth word is lost.
		word_ready <= 1'b0;
		for (int i = 0; i < 9; i++)
			send(16'h1200 + 16'(i), i < 8);
		idle();
		check("word_overrun", 16'(ovr), 16'h0001);
		word_ready <= 1'b1;
		idle();
		check("words left", 16'(expq.size()), 16'h0000);
		ticks = 0;
		repeat (10 * OSC_DIV)
		begin
			@(posedge clk);
			ticks += int'(timing_tick === 1'b1);
		end
		check("timing ticks", 16'(ticks), 16'h000A);
		// A long low pulse on the reset pin resets the port and the address counter, not the word buffer.
		reset_req <= 1'b1;
		@(posedge clk);
		reset_req <= 1'b0;
		n = 0;
		do step(); while (sys_reset !== 1'b1);
		check("reset delay", 16'(n >= RESET_CYC), 16'h0001);
		n = 0;
		do step(); while (sys_reset === 1'b1);
		idle();
		check("address after reset", 16'(address_counter), 16'(ADDR_RESET));
		finish_test();
	end
endmodule
